// File: shared/pmic_dc2_pkg.sv
// constants, field layout and types of the device-control-two register block
package pmic_dc2_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] DEVICE_CONTROL_OFFSET = 8'h3F;
    localparam logic [7:0] DEVICE_CONTROL_2_OFFSET = 8'h40;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int SWITCH_OFF_BIT = 0;
    localparam int SLEEP_LEVEL_BIT = 6;
    localparam int SLOT_LENGTH_LSB = 4;
    localparam int SLOT_LENGTH_MSB = 5;
    localparam int SLEEP_SIG_POL_BIT = 3;
    localparam int LONG_PRESS_OFF_BIT = 2;
    localparam int OFF_CORE_RESET_BIT = 1;
    localparam int IRQ_POLARITY_BIT = 0;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic SLEEP_LEVEL_RESET = 1'h0;
    localparam logic [1:0] SLOT_LENGTH_RESET = 2'h3;
    localparam logic SLEEP_SIG_POL_RESET = 1'h0;
    localparam logic LONG_PRESS_OFF_RESET = 1'h1;
    localparam logic OFF_CORE_RESET_RESET = 1'h0;
    localparam logic IRQ_POLARITY_RESET = 1'h0;
    localparam logic SWITCH_OFF_RESET = 1'h0;
    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int VOLT_W = 7;
    localparam int CLK_PERIOD_NS = 8;
    localparam int LONG_PRESS_US = 1000;
    // least time: round up to whole cycles
    localparam int LONG_PRESS_CYCLES = (LONG_PRESS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_ACTIVE,
        ST_SLEEP
    } power_state_t;
endpackage : pmic_dc2_pkg

// File: hw/long_press_timer.sv
// power-button hold timer: one pulse per press held for the long-press time
module long_press_timer #(
    parameter int HOLD_CYCLES = pmic_dc2_pkg::LONG_PRESS_CYCLES
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic button_low_in,
    output logic long_press_out
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic pulse_reg;
    logic pulse_next;

    always_comb begin
        count_next = count_reg;
        pulse_next = 1'b0;
        if (!button_low_in) begin
            count_next = 32'h0000_0000;
        end else if (count_reg < 32'(HOLD_CYCLES)) begin
            count_next = count_reg + 32'h0000_0001;
            // fire once when the hold reaches the limit, then park there
            pulse_next = (count_next == 32'(HOLD_CYCLES));
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            count_reg <= 32'h0000_0000;
            pulse_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            pulse_reg <= pulse_next;
        end
    end

    assign long_press_out = pulse_reg;
endmodule : long_press_timer

// File: hw/pmic_device_control_two.sv
// device-control-two register bank and the power state logic it steers
module pmic_device_control_two
    import pmic_dc2_pkg::*;
#(
    parameter int LONG_PRESS_HOLD = pmic_dc2_pkg::LONG_PRESS_CYCLES
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic boot_long_press_off_in,
    input wire logic boot_off_core_reset_in,
    input wire logic boot_irq_polarity_in,
    input wire logic power_button_input_n_in,
    input wire logic wake_request_in,
    input wire logic sleep_request_in,
    input wire logic irq_request_in,
    input wire logic [pmic_dc2_pkg::VOLT_W-1:0] active_voltage_in,
    input wire logic [pmic_dc2_pkg::VOLT_W-1:0] core_rail_sleep_voltage_reg_in,
    output logic [pmic_dc2_pkg::VOLT_W-1:0] converter_level_out,
    output logic irq_output_pad_out,
    output logic core_reset_out,
    output logic [1:0] power_state_out
);
    import pmic_dc2_pkg::*;

    // ----------------------------------------
    // register fields
    // ----------------------------------------
    logic converter_sleep_level_sel_reg, converter_sleep_level_sel_next;
    logic [1:0] sequence_slot_length_reg, sequence_slot_length_next;
    logic sleep_signal_polarity_reg, sleep_signal_polarity_next;
    logic button_long_press_off_en_reg, button_long_press_off_en_next;
    logic off_state_core_reset_en_reg, off_state_core_reset_en_next;
    logic irq_pad_polarity_reg, irq_pad_polarity_next;
    logic switch_off_request_reg, switch_off_request_next;
    logic boot_loaded_reg, boot_loaded_next;
    logic [7:0] rdata_reg, rdata_next;
    power_state_t state_reg, state_next;
    logic [VOLT_W-1:0] level_reg, level_next;
    logic irq_pad_reg, irq_pad_next;
    logic core_reset_reg, core_reset_next;
    logic long_press;
    logic wr_ctrl, wr_ctrl2;

    function automatic logic [7:0] ctrl2_image(input logic lvl, input logic [1:0] slot, input logic sig,
                                               input logic lpo, input logic lpr, input logic pol);
        logic [7:0] v;
        v = 8'h00; // top bit stays zero
        v[SLEEP_LEVEL_BIT] = lvl;
        v[SLOT_LENGTH_MSB:SLOT_LENGTH_LSB] = slot;
        v[SLEEP_SIG_POL_BIT] = sig;
        v[LONG_PRESS_OFF_BIT] = lpo;
        v[OFF_CORE_RESET_BIT] = lpr;
        v[IRQ_POLARITY_BIT] = pol;
        return v;
    endfunction : ctrl2_image

    long_press_timer #(
        .HOLD_CYCLES(LONG_PRESS_HOLD)
    ) u_long_press (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .button_low_in(~power_button_input_n_in),
        .long_press_out(long_press)
    );

    // ----------------------------------------
    // register access
    // ----------------------------------------
    assign wr_ctrl = reg_wr_in && (reg_addr_in == DEVICE_CONTROL_OFFSET) && boot_loaded_reg;
    assign wr_ctrl2 = reg_wr_in && (reg_addr_in == DEVICE_CONTROL_2_OFFSET) && boot_loaded_reg;

    always_comb begin
        converter_sleep_level_sel_next = converter_sleep_level_sel_reg;
        sequence_slot_length_next = sequence_slot_length_reg;
        sleep_signal_polarity_next = sleep_signal_polarity_reg;
        button_long_press_off_en_next = button_long_press_off_en_reg;
        off_state_core_reset_en_next = off_state_core_reset_en_reg;
        irq_pad_polarity_next = irq_pad_polarity_reg;
        switch_off_request_next = switch_off_request_reg;
        boot_loaded_next = 1'b1;
        rdata_next = rdata_reg;
        if (!boot_loaded_reg) begin
            // strap levels are taken on the first edge after reset release
            button_long_press_off_en_next = boot_long_press_off_in;
            off_state_core_reset_en_next = boot_off_core_reset_in;
            irq_pad_polarity_next = boot_irq_polarity_in;
        end else if (wr_ctrl2) begin
            converter_sleep_level_sel_next = reg_wdata_in[SLEEP_LEVEL_BIT];
            sequence_slot_length_next = reg_wdata_in[SLOT_LENGTH_MSB:SLOT_LENGTH_LSB];
            sleep_signal_polarity_next = reg_wdata_in[SLEEP_SIG_POL_BIT];
            button_long_press_off_en_next = reg_wdata_in[LONG_PRESS_OFF_BIT];
            off_state_core_reset_en_next = reg_wdata_in[OFF_CORE_RESET_BIT];
            irq_pad_polarity_next = reg_wdata_in[IRQ_POLARITY_BIT];
        end
        // hardware clear on reaching off; a write of one in that cycle wins
        if (state_reg == ST_OFF) begin
            switch_off_request_next = 1'b0;
        end
        if (wr_ctrl && reg_wdata_in[SWITCH_OFF_BIT]) begin
            switch_off_request_next = 1'b1;
        end
        if (reg_rd_in) begin
            if (reg_addr_in == DEVICE_CONTROL_2_OFFSET) begin
                rdata_next = ctrl2_image(converter_sleep_level_sel_reg, sequence_slot_length_reg,
                                         sleep_signal_polarity_reg, button_long_press_off_en_reg,
                                         off_state_core_reset_en_reg, irq_pad_polarity_reg);
            end else if (reg_addr_in == DEVICE_CONTROL_OFFSET) begin
                rdata_next = {7'h00, switch_off_request_reg};
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    // ----------------------------------------
    // power state and pad outputs
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (wake_request_in && !switch_off_request_reg) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (switch_off_request_reg || (long_press && button_long_press_off_en_reg)) begin
                    state_next = ST_OFF;
                end else if (sleep_request_in) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (switch_off_request_reg || (long_press && button_long_press_off_en_reg)) begin
                    state_next = ST_OFF;
                end else if (wake_request_in) begin
                    state_next = ST_ACTIVE;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        // level and core reset are registered from the next state, changing on the same edge as the state; the irq pad from the request; all from flops
        level_next = '0;
        if (state_next == ST_ACTIVE) begin
            level_next = active_voltage_in;
        end else if (state_next == ST_SLEEP && converter_sleep_level_sel_reg) begin
            level_next = core_rail_sleep_voltage_reg_in;
        end
        irq_pad_next = irq_pad_polarity_reg ? irq_request_in : ~irq_request_in;
        core_reset_next = (state_next == ST_OFF) && off_state_core_reset_en_reg;
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            converter_sleep_level_sel_reg <= SLEEP_LEVEL_RESET;
            sequence_slot_length_reg <= SLOT_LENGTH_RESET;
            sleep_signal_polarity_reg <= SLEEP_SIG_POL_RESET;
            button_long_press_off_en_reg <= LONG_PRESS_OFF_RESET;
            off_state_core_reset_en_reg <= OFF_CORE_RESET_RESET;
            irq_pad_polarity_reg <= IRQ_POLARITY_RESET;
            switch_off_request_reg <= SWITCH_OFF_RESET;
            boot_loaded_reg <= 1'b0;
            rdata_reg <= 8'h00;
            state_reg <= ST_OFF;
            level_reg <= '0;
            irq_pad_reg <= 1'b1;
            core_reset_reg <= 1'b0;
        end else begin
            converter_sleep_level_sel_reg <= converter_sleep_level_sel_next;
            sequence_slot_length_reg <= sequence_slot_length_next;
            sleep_signal_polarity_reg <= sleep_signal_polarity_next;
            button_long_press_off_en_reg <= button_long_press_off_en_next;
            off_state_core_reset_en_reg <= off_state_core_reset_en_next;
            irq_pad_polarity_reg <= irq_pad_polarity_next;
            switch_off_request_reg <= switch_off_request_next;
            boot_loaded_reg <= boot_loaded_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            level_reg <= level_next;
            irq_pad_reg <= irq_pad_next;
            core_reset_reg <= core_reset_next;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign converter_level_out = level_reg;
    assign irq_output_pad_out = irq_pad_reg;
    assign core_reset_out = core_reset_reg;
    assign power_state_out = state_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    a_sleep_level_select: assert property (
        (state_reg == ST_SLEEP) && $past(state_reg == ST_SLEEP) && $past(converter_sleep_level_sel_reg)
        |-> converter_level_out == $past(core_rail_sleep_voltage_reg_in))
        else $error("sleep level does not follow rail sleep voltage");
    a_sleep_level_zero: assert property (
        (state_reg == ST_SLEEP) && $past(state_reg == ST_SLEEP) && !$past(converter_sleep_level_sel_reg)
        |-> converter_level_out == '0)
        else $error("sleep level not zero with select clear");
    a_long_press_off: assert property (
        long_press && button_long_press_off_en_reg && (state_reg != ST_OFF) |=> state_reg == ST_OFF)
        else $error("long press did not switch off");
    a_long_press_held: assert property (
        (state_reg != ST_OFF) && !switch_off_request_reg && !button_long_press_off_en_reg |=> state_reg != ST_OFF)
        else $error("switched off without a request");
    a_core_reset_off: assert property (
        core_reset_out |-> (state_reg == ST_OFF) && $past(off_state_core_reset_en_reg))
        else $error("core reset outside off state or not allowed");
    a_irq_pad_level: assert property (
        boot_loaded_reg && $stable(irq_pad_polarity_reg) ##1 1'b1
        |-> irq_output_pad_out == ($past(irq_pad_polarity_reg) ~^ $past(irq_request_in)))
        else $error("interrupt pad level wrong for polarity");
    a_switch_off_path: assert property (
        switch_off_request_reg && (state_reg != ST_OFF) |=> state_reg == ST_OFF ##1 !switch_off_request_reg
            || $past(wr_ctrl))
        else $error("switch-off request did not reach off and clear");
    a_top_bit_zero: assert property (
        $past(reg_rd_in) && $past(reg_addr_in) == DEVICE_CONTROL_2_OFFSET |-> reg_rdata_out[7] == 1'b0)
        else $error("reserved top bit reads non-zero");
endmodule : pmic_device_control_two

// File: tb/pmic_device_control_two_tb_top.sv
// self-checking bench of the device-control-two register bank and its power state logic
module pmic_device_control_two_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmic_dc2_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [2:0] boot_bits = 3'b000;
    logic power_button_input_n_in = 1'b1;
    logic wake_request_in = 1'b0;
    logic sleep_request_in = 1'b0;
    logic irq_request_in = 1'b0;
    logic [VOLT_W-1:0] active_voltage_in = '0;
    logic [VOLT_W-1:0] core_rail_sleep_voltage_reg_in = '0;
    logic [VOLT_W-1:0] converter_level_out;
    logic irq_output_pad_out;
    logic core_reset_out;
    logic [1:0] power_state_out;
    int seed = 32'hd070_5e30;
    int error_cnt = 0;
    int num_checks = 0;
    int reg40 = 0;
    int mstate = 0;

    // --------------------------------------------------------
    // clock, design
    // --------------------------------------------------------
    initial begin
        forever #4 mclk_in = ~mclk_in;
    end

    // short hold time keeps the long-press runs brief
    pmic_device_control_two #(.LONG_PRESS_HOLD(8)) i_pmic_device_control_two (
        .mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .boot_long_press_off_in(boot_bits[2]), .boot_off_core_reset_in(boot_bits[1]),
        .boot_irq_polarity_in(boot_bits[0]), .power_button_input_n_in(power_button_input_n_in),
        .wake_request_in(wake_request_in), .sleep_request_in(sleep_request_in),
        .irq_request_in(irq_request_in), .active_voltage_in(active_voltage_in),
        .core_rail_sleep_voltage_reg_in(core_rail_sleep_voltage_reg_in),
        .converter_level_out(converter_level_out), .irq_output_pad_out(irq_output_pad_out),
        .core_reset_out(core_reset_out), .power_state_out(power_state_out));

    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk_in);
        reg_addr_in <= addr;
        reg_wdata_in <= data;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        if (addr == DEVICE_CONTROL_2_OFFSET) begin
            reg40 = data & 8'h7F;
        end
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge mclk_in);
        reg_addr_in <= addr;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp, "read data");
    endtask : reg_rd

    // one-cycle request pulse with fresh random levels on the analogue-side inputs
    task automatic pulse(input int which);
        @(posedge mclk_in);
        wake_request_in <= (which == 1);
        sleep_request_in <= (which == 2);
        active_voltage_in <= VOLT_W'($random(seed));
        core_rail_sleep_voltage_reg_in <= VOLT_W'($random(seed));
        irq_request_in <= 1'($random(seed));
        @(posedge mclk_in);
        wake_request_in <= 1'b0;
        sleep_request_in <= 1'b0;
        if (which != 0) begin
            mstate = which;
        end
    endtask : pulse

    task automatic check_out(input string what);
        logic [VOLT_W-1:0] lvl;
        repeat (5) @(posedge mclk_in);
        #1;
        lvl = '0;
        if (mstate == 1) begin
            lvl = active_voltage_in;
        end else if (mstate == 2 && reg40[6]) begin
            lvl = core_rail_sleep_voltage_reg_in;
        end
        chk(8'(power_state_out), 8'(mstate), what);
        chk(8'(converter_level_out), 8'(lvl), what);
        chk(8'(irq_output_pad_out), 8'(reg40[0] ? irq_request_in : !irq_request_in), what);
        chk(8'(core_reset_out), 8'(mstate == 0 && reg40[1]), what);
    endtask : check_out

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // --------------------------------------------------------
    // tests
    // --------------------------------------------------------
    initial begin
        boot_bits = 3'($random(seed));
        repeat (16) @(posedge mclk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        reg40 = 32'h30 | boot_bits;
        reg_rd(DEVICE_CONTROL_2_OFFSET, 8'(reg40));
        reg_wr(DEVICE_CONTROL_2_OFFSET, 8'hFF);
        reg_rd(DEVICE_CONTROL_2_OFFSET, 8'h7F);
        reg_wr(8'h55, 8'hAA);
        reg_rd(8'h55, 8'h00);
        reg_rd(DEVICE_CONTROL_2_OFFSET, 8'h7F);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            reg_wr(DEVICE_CONTROL_2_OFFSET, {1'b0, i[2], 4'b1101, i[1], i[0]});
            pulse(1);
            check_out("active");
            pulse(2);
            check_out("sleep");
            if (i[0]) begin
                pulse(1);
                check_out("wake from sleep");
            end
            reg_wr(DEVICE_CONTROL_OFFSET, 8'h01);
            // request still pending on the edge after the one that enters off, where the read samples it as it clears, so it reads back set
            reg_rd(DEVICE_CONTROL_OFFSET, 8'h01);
            mstate = 0;
            check_out("switched off");
            reg_rd(DEVICE_CONTROL_OFFSET, 8'h00);
        end
        $display("test power states done");
        for (int j = 0; j < 2; j++) begin
            reg_wr(DEVICE_CONTROL_2_OFFSET, {5'b00110, j[0], 2'b10});
            pulse(1);
            @(posedge mclk_in);
            power_button_input_n_in <= 1'b0;
            repeat (20) @(posedge mclk_in);
            power_button_input_n_in <= 1'b1;
            mstate = j ? 0 : 1;
            check_out("long press");
            reg_wr(DEVICE_CONTROL_OFFSET, 8'h01);
            mstate = 0;
            check_out("off again");
        end
        $display("test long press done");
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge mclk_in);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule : pmic_device_control_two_tb_top
